// ==== shared/yrc_pkg.sv ====
// Package: register map, field layout, reset values and types of the YUV to RGB converter.
package yrc_pkg;

    // ==========================================================
    // Register byte offsets on the bus.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BIAS = 8'h04;
    localparam logic [7:0] REG_COEF_R = 8'h08;
    localparam logic [7:0] REG_COEF_G = 8'h0c;
    localparam logic [7:0] REG_COEF_B = 8'h10;
    localparam logic [7:0] REG_LUT_ADDR = 8'h14;
    localparam logic [7:0] REG_LUT_DATA = 8'h18;
    localparam logic [7:0] REG_GEOM_X = 8'h1c;
    localparam logic [7:0] REG_OFFSET_X = 8'h20;
    localparam logic [7:0] REG_STATUS = 8'h24;

    // ==========================================================
    // Control fields and reset values.
    localparam int CTRL_FMT_LSB = 0;
    localparam int CTRL_ACHRO = 3;
    localparam int CTRL_INTERP = 4;
    localparam int CTRL_LUT_EN = 5;
    localparam int CTRL_RGB_FORCE = 6;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] BIAS_RST = 32'h0000_0000;
    localparam logic [31:0] COEF_R_RST = 32'h0000_0080;
    localparam logic [31:0] COEF_G_RST = 32'h0000_0080;
    localparam logic [31:0] COEF_B_RST = 32'h0000_0080;
    localparam int GEOM_W = 12;
    localparam int GEOM_WIDTH_LSB = 16;
    localparam int FRAC_BITS = 7;
    localparam int SUM_W = 21;

    // ==========================================================
    // Input formats and pair sequencer states.
    typedef enum logic [2:0] {
        YRC_FMT_422 = 3'h0,
        YRC_FMT_444 = 3'h1,
        YRC_FMT_555 = 3'h2,
        YRC_FMT_655 = 3'h3,
        YRC_FMT_RGB = 3'h4
    } yrc_fmt_e;

    typedef enum logic [1:0] {
        YRC_ST_EMPTY = 2'h0,
        YRC_ST_EVEN = 2'h1,
        YRC_ST_ODD = 2'h2
    } yrc_step_e;

endpackage

// ==== verification/yrc_converter_tb_top.sv ====
// Testbench: register and pixel sequences with expected RGB words.
`timescale 1ns/10ps
module yrc_converter_tb_top;
    // ==========================================================
    // Signals.
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, pv = 1'b0, pl = 1'b0, stall = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rd_o, pd = 32'h0, rd;
    logic ack, prdy, rv, rrdy;
    logic [23:0] rgb;
    logic [11:0] fx, wx, ox;
    logic [23:0] got[$];
    int bad_count = 0, checked = 0;
    yrc_converter DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd_o),
        .wb_ack_o(ack), .pix_valid_i(pv), .pix_ready_o(prdy), .pix_data_i(pd), .pix_last_i(pl),
        .rgb_valid_o(rv), .rgb_ready_i(rrdy), .rgb_data_o(rgb), .layer_first_pixel_x_o(fx),
        .layer_window_width_o(wx), .display_offset_x_o(ox));
    yrc_sink_model sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .ready_o(rrdy));
    // Clock generation, 8 ns period.
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    // Every word the sink accepts is queued in pixel order.
    always @(posedge clk_i) begin
        if (rv && rrdy) got.push_back(rgb);
    end
    // ==========================================================
    // Tasks.
    task automatic results();
        $display("Comparisons %0d, mismatches %0d.", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // A hung handshake counts as a mismatch and ends the run.
    task automatic hang();
        bad_count++;
        $display("[FAIL] %0t handshake timed out", $time);
        results();
    endtask
    // One classic Wishbone cycle, held until ack, then one idle cycle.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        if (n == 50) hang();
        rd = rd_o;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic px(input logic [31:0] d, input logic last);
        int n;
        pv <= 1'b1;
        pd <= d;
        pl <= last;
        for (n = 0; n < 200; n++) begin
            @(posedge clk_i);
            if (prdy === 1'b1) break;
        end
        if (n == 200) hang();
        pv <= 1'b0;
        // Let one edge pass so a following call never re-drives valid in the same step.
        @(posedge clk_i);
    endtask
    task automatic expect_rgb(input logic [23:0] exp);
        int n;
        for (n = 0; n < 200 && got.size() == 0; n++) @(posedge clk_i);
        if (got.size() == 0) hang();
        check({8'h0, got.pop_front()}, {8'h0, exp});
    endtask
    // ==========================================================
    // Main sequence.
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, yrc_pkg::REG_CTRL, 32'h0);
        check(rd, yrc_pkg::CTRL_RST);
        wb(1'b0, yrc_pkg::REG_COEF_G, 32'h0);
        check(rd, yrc_pkg::COEF_G_RST);
        wb(1'b0, 8'h3c, 32'h0);
        check(rd, 32'h0);
        px(32'h0040_1122, 1'b0);
        expect_rgb(24'h404040);
        wb(1'b1, yrc_pkg::REG_BIAS, 32'h0000_0080);
        px(32'h0040_0000, 1'b0);
        expect_rgb(24'h000000);
        wb(1'b1, yrc_pkg::REG_BIAS, 32'h0000_007f);
        px(32'h00f0_0000, 1'b0);
        expect_rgb(24'hffffff);
        wb(1'b1, yrc_pkg::REG_BIAS, 32'h0);
        // G = 128 - 65/2 = 95.5, floored once to 0x5f.
        wb(1'b1, yrc_pkg::REG_COEF_G, 32'h0000_4080);
        px(32'h0080_4100, 1'b0);
        expect_rgb(24'h805f80);
        // Zero luma weight leaves only the negated chroma term, which clips to zero.
        wb(1'b1, yrc_pkg::REG_COEF_G, 32'h0000_4000);
        px(32'h0080_4100, 1'b0);
        expect_rgb(24'h800080);
        wb(1'b1, yrc_pkg::REG_COEF_G, 32'h0000_4080);
        wb(1'b1, yrc_pkg::REG_CTRL, 32'h0000_0009);
        px(32'h0080_4100, 1'b0);
        expect_rgb(24'h808080);
        wb(1'b1, yrc_pkg::REG_COEF_R, 32'h0000_8080);
        wb(1'b1, yrc_pkg::REG_COEF_B, 32'h0080_0080);
        wb(1'b1, yrc_pkg::REG_CTRL, 32'h0);
        px(32'h1030_2040, 1'b1);
        expect_rgb(24'h603050);
        expect_rgb(24'h502040);
        wb(1'b1, yrc_pkg::REG_CTRL, 32'h0000_0010);
        stall <= 1'b1;
        px(32'h1030_2040, 1'b0);
        px(32'h3030_4040, 1'b1);
        expect_rgb(24'h603050);
        expect_rgb(24'h601850);
        expect_rgb(24'h802070);
        expect_rgb(24'h701060);
        stall <= 1'b0;
        // Five-bit channels are widened by repeating their top bits.
        wb(1'b1, yrc_pkg::REG_CTRL, 32'h0000_0002);
        px(32'h0000_4001, 1'b0);
        expect_rgb(24'h84848c);
        // Load one entry per table through the auto-incrementing data port.
        wb(1'b1, yrc_pkg::REG_LUT_ADDR, 32'h0000_0010);
        wb(1'b1, yrc_pkg::REG_LUT_DATA, 32'h0000_00a1);
        wb(1'b1, yrc_pkg::REG_LUT_ADDR, 32'h0000_0120);
        wb(1'b1, yrc_pkg::REG_LUT_DATA, 32'h0000_00b2);
        wb(1'b1, yrc_pkg::REG_LUT_ADDR, 32'h0000_0230);
        wb(1'b1, yrc_pkg::REG_LUT_DATA, 32'h0000_00c3);
        wb(1'b1, yrc_pkg::REG_LUT_ADDR, 32'h0000_0010);
        wb(1'b0, yrc_pkg::REG_LUT_DATA, 32'h0);
        check(rd, 32'h0000_00a1);
        // RGB input under forcing goes through the tables.
        wb(1'b1, yrc_pkg::REG_CTRL, 32'h0000_0044);
        px(32'h0010_2030, 1'b0);
        expect_rgb(24'ha1b2c3);
        // YUV output under forcing must bypass the tables even with them enabled.
        wb(1'b1, yrc_pkg::REG_CTRL, 32'h0000_0061);
        px(32'h0010_0000, 1'b0);
        expect_rgb(24'h101010);
        wb(1'b1, yrc_pkg::REG_CTRL, 32'h0);
        wb(1'b1, yrc_pkg::REG_GEOM_X, 32'h0007_0005);
        wb(1'b1, yrc_pkg::REG_OFFSET_X, 32'h0000_0003);
        check({8'h0, fx, wx}, 32'h0000_4006);
        check({20'h0, ox}, 32'h2);
        // Fifteen pixels entered the buffer; it is drained and the sequencer idle.
        wb(1'b0, yrc_pkg::REG_STATUS, 32'h0);
        check(rd, 32'h000f_0000);
        results();
    end
endmodule // yrc_converter_tb_top

// ==== verification/yrc_sink_model.sv ====
// Downstream sink model: takes RGB words from the converter, stalling when asked.
`timescale 1ns/10ps
module yrc_sink_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Stall request from the bench and ready toward the converter.
    input wire logic stall_i,
    output logic ready_o
);
    // ==========================================================
    // Stall pattern.
    logic [1:0] phase_reg;
    // Ready one cycle in four while stalling, so the buffer fills and must hold its words.
    always_ff @(posedge clk_i) begin
        phase_reg <= rst_i ? 2'h0 : phase_reg + 2'h1;
    end
    assign ready_o = !stall_i || (phase_reg == 2'h3);
endmodule // yrc_sink_model

// ==== verilog/yrc_converter.sv ====
// Module: YUV to RGB pixel converter with Wishbone register slave and output buffer.
`timescale 1ns/10ps
module yrc_converter #(
    parameter int DEPTH = 2,
    parameter int WIDTH = 24
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pixel stream from the fetch stage.
    input wire logic pix_valid_i,
    output logic pix_ready_o,
    input wire logic [31:0] pix_data_i,
    input wire logic pix_last_i,
    // RGB stream toward colour mapping.
    output logic rgb_valid_o,
    input wire logic rgb_ready_i,
    output logic [WIDTH-1:0] rgb_data_o,
    // Effective layer geometry for the fetch unit.
    output logic [yrc_pkg::GEOM_W-1:0] layer_first_pixel_x_o,
    output logic [yrc_pkg::GEOM_W-1:0] layer_window_width_o,
    output logic [yrc_pkg::GEOM_W-1:0] display_offset_x_o
);

    // ==========================================================
    // Register file.
    logic [31:0] ctrl_reg, ctrl_next, bias_reg, bias_next, rdat_reg, rdat_next, wmask, wtmp;
    logic [31:0] coef_reg [3];
    logic [31:0] coef_next [3];
    logic [9:0] lut_ptr_reg, lut_ptr_next;
    logic [yrc_pkg::GEOM_W-1:0] fx_reg, fx_next, wx_reg, wx_next, ox_reg, ox_next;
    logic [15:0] pix_cnt_reg, pix_cnt_next;
    logic ack_reg, ack_next, req, wr, lut_we, is422;
    logic [7:0] lut_mem [3][256];
    logic [7:0] lut_bus_rd;
    yrc_pkg::yrc_fmt_e fmt;
    yrc_pkg::yrc_step_e st_reg, st_next;
    localparam int PW = $clog2(DEPTH);
    logic [PW:0] cnt_reg, cnt_next;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [31:0] m);
        return (o & ~m) | (n & m);
    endfunction

    assign fmt = yrc_pkg::yrc_fmt_e'(ctrl_reg[yrc_pkg::CTRL_FMT_LSB +: 3]);
    assign is422 = fmt == yrc_pkg::YRC_FMT_422;
    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr = req && wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign lut_bus_rd = (lut_ptr_reg[9:8] == 2'h3) ? 8'h00 : lut_mem[lut_ptr_reg[9:8]][lut_ptr_reg[7:0]];
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    assign layer_first_pixel_x_o = {fx_reg[yrc_pkg::GEOM_W-1:1], fx_reg[0] & !is422};
    assign layer_window_width_o = {wx_reg[yrc_pkg::GEOM_W-1:1], wx_reg[0] & !is422};
    assign display_offset_x_o = {ox_reg[yrc_pkg::GEOM_W-1:1], ox_reg[0] & !is422};

    // Bus decode; unmapped addresses are acknowledged, read as zero and ignore writes.
    always_comb begin
        ctrl_next = ctrl_reg;
        bias_next = bias_reg;
        coef_next = coef_reg;
        lut_ptr_next = lut_ptr_reg;
        fx_next = fx_reg;
        wx_next = wx_reg;
        ox_next = ox_reg;
        lut_we = 1'b0;
        ack_next = req;
        rdat_next = 32'h0000_0000;
        wtmp = merge({4'h0, wx_reg, 4'h0, fx_reg}, wb_dat_i, wmask);
        if (wr) begin
            case (wb_adr_i)
                yrc_pkg::REG_CTRL: ctrl_next = merge(ctrl_reg, wb_dat_i, wmask) & 32'h0000_007f;
                yrc_pkg::REG_BIAS: bias_next = merge(bias_reg, wb_dat_i, wmask) & 32'h00ff_ffff;
                yrc_pkg::REG_COEF_R: coef_next[0] = merge(coef_reg[0], wb_dat_i, wmask) & 32'h00ff_ffff;
                yrc_pkg::REG_COEF_G: coef_next[1] = merge(coef_reg[1], wb_dat_i, wmask) & 32'h00ff_ffff;
                yrc_pkg::REG_COEF_B: coef_next[2] = merge(coef_reg[2], wb_dat_i, wmask) & 32'h00ff_ffff;
                yrc_pkg::REG_LUT_ADDR: begin
                    lut_ptr_next[9:8] = wb_sel_i[1] ? wb_dat_i[9:8] : lut_ptr_reg[9:8];
                    lut_ptr_next[7:0] = wb_sel_i[0] ? wb_dat_i[7:0] : lut_ptr_reg[7:0];
                end
                yrc_pkg::REG_LUT_DATA: begin
                    // Auto-increment lets software stream a whole table with one address write.
                    lut_we = wb_sel_i[0];
                    lut_ptr_next[7:0] = wb_sel_i[0] ? lut_ptr_reg[7:0] + 8'h01 : lut_ptr_reg[7:0];
                end
                yrc_pkg::REG_GEOM_X: begin
                    fx_next = wtmp[yrc_pkg::GEOM_W-1:0];
                    wx_next = wtmp[yrc_pkg::GEOM_WIDTH_LSB +: yrc_pkg::GEOM_W];
                end
                yrc_pkg::REG_OFFSET_X: ox_next = wb_sel_i[0] ? {ox_reg[11:8], wb_dat_i[7:0]} : ox_reg;
                default: ;
            endcase
            if (wb_adr_i == yrc_pkg::REG_OFFSET_X && wb_sel_i[1]) begin
                ox_next[11:8] = wb_dat_i[11:8];
            end
        end else if (req) begin
            case (wb_adr_i)
                yrc_pkg::REG_CTRL: rdat_next = ctrl_reg;
                yrc_pkg::REG_BIAS: rdat_next = bias_reg;
                yrc_pkg::REG_COEF_R: rdat_next = coef_reg[0];
                yrc_pkg::REG_COEF_G: rdat_next = coef_reg[1];
                yrc_pkg::REG_COEF_B: rdat_next = coef_reg[2];
                yrc_pkg::REG_LUT_ADDR: rdat_next = {22'h0, lut_ptr_reg};
                yrc_pkg::REG_LUT_DATA: rdat_next = {24'h000000, lut_bus_rd};
                yrc_pkg::REG_GEOM_X: rdat_next = {4'h0, layer_window_width_o, 4'h0, layer_first_pixel_x_o};
                yrc_pkg::REG_OFFSET_X: rdat_next = {20'h00000, display_offset_x_o};
                yrc_pkg::REG_STATUS: rdat_next = {pix_cnt_reg, 12'h000, st_reg, 2'(cnt_reg)};
                default: ;
            endcase
        end
    end

    // Register update.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= yrc_pkg::CTRL_RST;
            bias_reg <= yrc_pkg::BIAS_RST;
            coef_reg[0] <= yrc_pkg::COEF_R_RST;
            coef_reg[1] <= yrc_pkg::COEF_G_RST;
            coef_reg[2] <= yrc_pkg::COEF_B_RST;
            lut_ptr_reg <= 10'h000;
            fx_reg <= 12'h000;
            wx_reg <= 12'h000;
            ox_reg <= 12'h000;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            bias_reg <= bias_next;
            coef_reg <= coef_next;
            lut_ptr_reg <= lut_ptr_next;
            fx_reg <= fx_next;
            wx_reg <= wx_next;
            ox_reg <= ox_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    // ==========================================================
    // Input decode and pair sequencer.
    logic [7:0] in_y0, in_y1, in_u, in_v, hy0_reg, hy1_reg, hu_reg, hv_reg;
    logic [7:0] hy0_next, hy1_next, hu_next, hv_next, e_y, e_u, e_v;
    logic hlast_reg, hlast_next, emit, adv, in_fire, interp_on, full, push, pop;

    always_comb begin
        in_y0 = pix_data_i[23:16];
        in_y1 = pix_data_i[23:16];
        in_u = pix_data_i[15:8];
        in_v = pix_data_i[7:0];
        case (fmt)
            yrc_pkg::YRC_FMT_422: begin
                in_y0 = pix_data_i[7:0];
                in_u = pix_data_i[15:8];
                in_y1 = pix_data_i[23:16];
                in_v = pix_data_i[31:24];
            end
            yrc_pkg::YRC_FMT_555: begin
                in_y1 = {pix_data_i[14:10], pix_data_i[14:12]};
                in_u = {pix_data_i[9:5], pix_data_i[9:7]};
                in_v = {pix_data_i[4:0], pix_data_i[4:2]};
            end
            yrc_pkg::YRC_FMT_655: begin
                in_y1 = {pix_data_i[15:10], pix_data_i[15:14]};
                in_u = {pix_data_i[9:5], pix_data_i[9:7]};
                in_v = {pix_data_i[4:0], pix_data_i[4:2]};
            end
            default: ;
        endcase
    end

    // Interpolation waits for the next pair, so the last pair of a line is flagged to flush.
    assign interp_on = ctrl_reg[yrc_pkg::CTRL_INTERP] && is422 && !hlast_reg;
    assign adv = !full;
    assign pix_ready_o = st_reg == yrc_pkg::YRC_ST_EMPTY || (st_reg == yrc_pkg::YRC_ST_ODD && emit);
    assign in_fire = pix_valid_i && pix_ready_o;

    always_comb begin
        emit = 1'b0;
        e_y = hy0_reg;
        e_u = hu_reg;
        e_v = hv_reg;
        unique case (st_reg)
            yrc_pkg::YRC_ST_EMPTY: ;
            yrc_pkg::YRC_ST_EVEN: emit = adv;
            yrc_pkg::YRC_ST_ODD: begin
                emit = adv && (!interp_on || pix_valid_i);
                e_y = hy1_reg;
                if (interp_on) begin
                    e_u = 8'((({1'b0, hu_reg} + {1'b0, in_u}) >> 1));
                    e_v = 8'((({1'b0, hv_reg} + {1'b0, in_v}) >> 1));
                end
            end
            default: ;
        endcase
        st_next = st_reg;
        hy0_next = hy0_reg;
        hy1_next = hy1_reg;
        hu_next = hu_reg;
        hv_next = hv_reg;
        hlast_next = hlast_reg;
        if (emit) begin
            st_next = (st_reg == yrc_pkg::YRC_ST_EVEN) ? yrc_pkg::YRC_ST_ODD : yrc_pkg::YRC_ST_EMPTY;
        end
        if (in_fire) begin
            st_next = is422 ? yrc_pkg::YRC_ST_EVEN : yrc_pkg::YRC_ST_ODD;
            hy0_next = in_y0;
            hy1_next = in_y1;
            hu_next = in_u;
            hv_next = in_v;
            hlast_next = pix_last_i || !is422;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= yrc_pkg::YRC_ST_EMPTY;
            hy0_reg <= 8'h00;
            hy1_reg <= 8'h00;
            hu_reg <= 8'h00;
            hv_reg <= 8'h00;
            hlast_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            hy0_reg <= hy0_next;
            hy1_reg <= hy1_next;
            hu_reg <= hu_next;
            hv_reg <= hv_next;
            hlast_reg <= hlast_next;
        end
    end

    // ==========================================================
    // Matrix, clip and table stages; every stage holds while the buffer is full.
    logic signed [9:0] b_y, b_u, b_v;
    logic [7:0] ech [3];
    logic [7:0] s2_data [3];
    logic [7:0] s2_next [3];
    logic s1_vld_reg, s1_vld_next, s1_lut_reg, s1_lut_next, s2_vld_reg, s2_vld_next;
    logic signed [yrc_pkg::SUM_W-1:0] s1_sum [3];
    logic gray, rgb;

    assign gray = ctrl_reg[yrc_pkg::CTRL_ACHRO] && fmt != yrc_pkg::YRC_FMT_RGB;
    assign rgb = fmt == yrc_pkg::YRC_FMT_RGB;
    assign ech[0] = e_y;
    assign ech[1] = gray ? e_y : e_u;
    assign ech[2] = gray ? e_y : e_v;
    assign b_y = $signed({2'b00, e_y}) + $signed({{2{bias_reg[7]}}, bias_reg[7:0]});
    assign b_u = $signed({2'b00, e_u}) + $signed({{2{bias_reg[15]}}, bias_reg[15:8]});
    assign b_v = $signed({2'b00, e_v}) + $signed({{2{bias_reg[23]}}, bias_reg[23:16]});

    // Table use: RGB input only under forcing; YUV matrix output only when not forcing.
    always_comb begin
        s1_vld_next = adv ? emit : s1_vld_reg;
        s2_vld_next = adv ? s1_vld_reg : s2_vld_reg;
        s1_lut_next = s1_lut_reg;
        if (adv) begin
            s1_lut_next = rgb ? ctrl_reg[yrc_pkg::CTRL_RGB_FORCE]
                              : ctrl_reg[yrc_pkg::CTRL_LUT_EN] && !ctrl_reg[yrc_pkg::CTRL_RGB_FORCE] && !gray;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_vld_reg <= 1'b0;
            s1_lut_reg <= 1'b0;
            s2_vld_reg <= 1'b0;
        end else begin
            s1_vld_reg <= s1_vld_next;
            s1_lut_reg <= s1_lut_next;
            s2_vld_reg <= s2_vld_next;
        end
    end

    for (genvar r = 0; r < 3; r++) begin : g_row
        logic signed [yrc_pkg::SUM_W-1:0] p_y, p_u, p_v, sum, s1_sum_next;
        logic [7:0] clip;
        assign p_y = b_y * $signed({1'b0, coef_reg[r][7:0]});
        assign p_u = b_u * $signed({1'b0, coef_reg[r][15:8]});
        assign p_v = b_v * $signed({1'b0, coef_reg[r][23:16]});
        if (r == 1) begin : g_green
            assign sum = p_y - p_u - p_v;
        end else begin : g_other
            assign sum = p_y + p_u + p_v;
        end
        assign clip = (s1_sum[r] < 0) ? 8'h00
                    : (s1_sum[r][yrc_pkg::SUM_W-1:yrc_pkg::FRAC_BITS+8] != '0) ? 8'hff
                    : s1_sum[r][yrc_pkg::FRAC_BITS +: 8];
        always_comb begin
            s1_sum_next = s1_sum[r];
            s2_next[r] = s2_data[r];
            if (adv) begin
                s1_sum_next = (gray || rgb) ? $signed({6'h00, ech[r], 7'h00}) : sum;
                s2_next[r] = s1_lut_reg ? lut_mem[r][clip] : clip;
            end
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                s1_sum[r] <= '0;
                s2_data[r] <= 8'h00;
            end else begin
                s1_sum[r] <= s1_sum_next;
                s2_data[r] <= s2_next[r];
            end
        end
        // Table storage, written from the bus only.
        always_ff @(posedge clk_i) begin
            if (lut_we && lut_ptr_reg[9:8] == 2'(r)) begin
                lut_mem[r][lut_ptr_reg[7:0]] <= wb_dat_i[7:0];
            end
        end
    end

    // ==========================================================
    // Output buffer; a stall downstream fills it and then halts the pipeline.
    logic [WIDTH-1:0] fifo_mem [DEPTH];
    logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;

    assign full = cnt_reg == (PW+1)'(DEPTH);
    assign push = s2_vld_reg && !full;
    assign pop = rgb_valid_o && rgb_ready_i;
    assign rgb_valid_o = cnt_reg != '0;
    assign rgb_data_o = fifo_mem[rp_reg];

    always_comb begin
        wp_next = push ? ((wp_reg == PW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1) : wp_reg;
        rp_next = pop ? ((rp_reg == PW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1) : rp_reg;
        cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
        pix_cnt_next = pix_cnt_reg + 16'(push);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            pix_cnt_reg <= 16'h0000;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            pix_cnt_reg <= pix_cnt_next;
        end
        if (push) begin
            fifo_mem[wp_reg] <= {s2_data[0], s2_data[1], s2_data[2]};
        end
    end

    // ==========================================================
    // Assertions and cover points.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_gray_equal;
        s2_vld_reg && $past(gray, 2) && !$past(s1_lut_reg) |-> s2_data[0] == s2_data[2];
    endproperty
    a_gray_equal: assert property (p_gray_equal) else $error("gray channels differ");
    property p_even_geom;
        is422 |-> !layer_first_pixel_x_o[0] && !layer_window_width_o[0] && !display_offset_x_o[0];
    endproperty
    a_even_geom: assert property (p_even_geom) else $error("odd geometry in 4:2:2");
    property p_pair_load;
        in_fire && is422 |=> st_reg == yrc_pkg::YRC_ST_EVEN && hu_reg == $past(pix_data_i[15:8])
                             && hv_reg == $past(pix_data_i[31:24]);
    endproperty
    a_pair_load: assert property (p_pair_load) else $error("pair chroma wrong");
    // The held pair chroma must survive into the odd pixel; interpolation may only average it.
    property p_pair_order;
        emit && st_reg == yrc_pkg::YRC_ST_EVEN |=> st_reg == yrc_pkg::YRC_ST_ODD
            && hu_reg == $past(hu_reg) && hv_reg == $past(hv_reg)
            && (interp_on || (e_u == $past(e_u) && e_v == $past(e_v)));
    endproperty
    a_pair_order: assert property (p_pair_order) else $error("pair not shared");
    property p_interp;
        emit && interp_on |-> e_u <= (hu_reg > in_u ? hu_reg : in_u) && e_u >= (hu_reg > in_u ? in_u : hu_reg);
    endproperty
    a_interp: assert property (p_interp) else $error("average out of range");
    property p_scale555;
        in_fire && fmt == yrc_pkg::YRC_FMT_555 |=> hy1_reg[2:0] == hy1_reg[7:5];
    endproperty
    a_scale555: assert property (p_scale555) else $error("5-bit scaling wrong");
    property p_clip_low;
        adv && s1_vld_reg && !s1_lut_reg && s1_sum[1] < 0 |=> s2_data[1] == 8'h00;
    endproperty
    a_clip_low: assert property (p_clip_low) else $error("negative not clipped");
    property p_clip_high;
        adv && s1_vld_reg && !s1_lut_reg && s1_sum[0] > 21'sd32767 |=> s2_data[0] == 8'hff;
    endproperty
    a_clip_high: assert property (p_clip_high) else $error("overflow not clipped");
    property p_force;
        adv && emit && !rgb && ctrl_reg[yrc_pkg::CTRL_RGB_FORCE] |=> !s1_lut_reg;
    endproperty
    a_force: assert property (p_force) else $error("table used under forcing");
    property p_green;
        adv && emit && !gray && !rgb && coef_reg[1][7:0] == 8'h00 && e_u != 8'h00
            && bias_reg[15:8] == 8'h00 && coef_reg[1][15:8] != 8'h00 && bias_reg[23:16] == 8'h00
            |=> s1_sum[1] < 0;
    endproperty
    a_green: assert property (p_green) else $error("green chroma not negative");
    property p_fifo;
        cnt_reg <= (PW+1)'(DEPTH) && !(full && push);
    endproperty
    a_fifo: assert property (p_fifo) else $error("buffer overrun");
    property p_ack;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack longer than one cycle");

    c_full: cover property (full ##1 pop);
    c_interp: cover property (emit && interp_on);
    c_gray: cover property (emit && gray);
    c_lut: cover property (s2_vld_reg && s1_lut_reg);

endmodule // yrc_converter
